// ### sim/host_input_port_checker.sv
// port-level assertions for the host input front end
// assumes one clock domain, sys_rst synchronous and active high
`timescale 1ns/100ps
module host_input_port_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flow_mode_sw,
  input wire logic alarm_state,
  input wire logic paper_out,
  input wire logic buf_out_ready,
  input wire logic busy,
  input wire logic byte_request_pulse_n,
  input wire logic alarm_out_n,
  input wire logic paper_out_flag,
  input wire logic dtr,
  input wire logic txd,
  input wire logic buf_out_valid,
  input wire logic [7:0] buf_out_data,
  input wire logic not_ready
);
  // ========
  // helper: cycles the acknowledge has been low so far
  logic [7:0] ack_cnt;
  logic [7:0] next_ack_cnt;
  always_comb begin
    next_ack_cnt = byte_request_pulse_n ? 8'h00 : ack_cnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_cnt <= 8'h00;
    end else begin
      ack_cnt <= next_ack_cnt;
    end
  end

  // ========
  // properties; a board reset in mid pulse would cut the width short
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack_width; $rose(byte_request_pulse_n) |-> ack_cnt == 8'(host_input_pkg::ACK_CYCLES); endproperty
  a_ack_width: assert property (p_ack_width) else $error("acknowledge width wrong");
  property p_ack_busy; !byte_request_pulse_n |-> busy; endproperty
  a_ack_busy: assert property (p_ack_busy) else $error("acknowledge outside busy");
  property p_busy_end; $rose(byte_request_pulse_n) |-> !busy; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not low at acknowledge end");
  property p_rst; $fell(sys_rst) |-> busy && not_ready && txd && !buf_out_valid ##1 busy; endproperty
  a_rst: assert property (p_rst) else $error("ready during reset or power-up");
  property p_dtr_code; flow_mode_sw [*5] |-> dtr == host_input_pkg::LINE_SPACE; endproperty
  a_dtr_code: assert property (p_dtr_code) else $error("dtr not space in code flow");
  property p_dtr_hw; !flow_mode_sw [*5] |-> dtr == not_ready; endproperty
  a_dtr_hw: assert property (p_dtr_hw) else $error("dtr does not follow readiness");
  property p_txd_hw; !flow_mode_sw [*5] |-> txd; endproperty
  a_txd_hw: assert property (p_txd_hw) else $error("code sent in dtr flow");
  property p_alarm; alarm_out_n == !alarm_state; endproperty
  a_alarm: assert property (p_alarm) else $error("fault output wrong");
  property p_halt; alarm_state [*2] |-> busy && not_ready; endproperty
  a_halt: assert property (p_halt) else $error("ready during alarm");
  property p_paper; paper_out_flag == paper_out; endproperty
  a_paper: assert property (p_paper) else $error("paper out flag wrong");
  property p_hold; buf_out_valid && !buf_out_ready |=> buf_out_valid && $stable(buf_out_data); endproperty
  a_hold: assert property (p_hold) else $error("output byte lost in stall");
endmodule

bind host_input_port host_input_port_checker host_input_port_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .flow_mode_sw(flow_mode_sw), .alarm_state(alarm_state), .paper_out(paper_out), .buf_out_ready(buf_out_ready),
  .busy(busy), .byte_request_pulse_n(byte_request_pulse_n), .alarm_out_n(alarm_out_n),
  .paper_out_flag(paper_out_flag), .dtr(dtr), .txd(txd), .buf_out_valid(buf_out_valid),
  .buf_out_data(buf_out_data), .not_ready(not_ready));

// ### sim/host_input_port_tb.sv
// self-checking bench for the host input front end
// assumes the package, design, checker and host model are compiled first
`timescale 1ns/100ps
module host_input_port_tb;
  localparam int B1 = 40;
  localparam int LIMIT = 90000;
  logic clk, sys_rst, host_board_reset_n, flow_mode_sw, rxd, host_strobe_n, alarm_state, paper_out;
  logic test_print, buf_out_ready, busy, byte_request_pulse_n, alarm_out_n, paper_out_flag, dtr, txd;
  logic buf_out_valid, not_ready;
  logic [3:0] format_select_sw;
  logic [7:0] host_byte_bus, buf_out_data, d, e;
  logic [7:0] expq[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'hbeab;
  int rt[5] = '{B1, B1 / 2, B1 / 4, host_input_pkg::BIT_CYCLES_9600, host_input_pkg::BIT_CYCLES_19200};

  host_input_port #(.BIT_CYCLES_1200(B1), .BIT_CYCLES_2400(B1 / 2), .BIT_CYCLES_4800(B1 / 4),
    .POWERUP_CYCLES(20)) host_input_port_inst (.clk(clk), .sys_rst(sys_rst),
    .host_board_reset_n(host_board_reset_n), .format_select_sw(format_select_sw), .flow_mode_sw(flow_mode_sw),
    .rxd(rxd), .host_byte_bus(host_byte_bus), .host_strobe_n(host_strobe_n), .alarm_state(alarm_state),
    .paper_out(paper_out), .test_print(test_print), .buf_out_ready(buf_out_ready), .busy(busy),
    .byte_request_pulse_n(byte_request_pulse_n), .alarm_out_n(alarm_out_n), .paper_out_flag(paper_out_flag),
    .dtr(dtr), .txd(txd), .buf_out_valid(buf_out_valid), .buf_out_data(buf_out_data), .not_ready(not_ready));
  host_link_model #(.CODE_BIT(B1)) host_link_model_inst (.clk(clk), .busy(busy), .dtr(dtr), .txd(txd),
    .rxd(rxd), .host_strobe_n(host_strobe_n), .host_byte_bus(host_byte_bus));

  // ========
  // clock, watchdog and random drain stalls
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    #1 buf_out_ready = ($random(seed) % 3) != 0;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end

  // ========
  // drain side: each accepted byte meets the oldest note
  always @(negedge clk) begin
    if (sys_rst === 1'b0 && buf_out_valid === 1'b1 && buf_out_ready === 1'b1 && alarm_state === 1'b0) begin
      e = 8'hxx;
      if (expq.size() > 0) e = expq.pop_front();
      check(buf_out_data, e);
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ser(input logic [7:0] v, input logic [7:0] x, input int c, input logic [2:0] flt);
    expq.push_back(x);
    host_link_model_inst.send_ser(v, rt[(c - 1) % 5], (c > 10) ? 2 : (c > 5) ? 1 : 0, flt);
  endtask

  task automatic fmt(input int c);
    @(posedge clk) #1 format_select_sw = 4'(c);
    repeat (6) @(posedge clk);
  endtask

  // bounded wait for the notes to drain, then one line per test
  task automatic done(input string s);
    for (int k = 0; k < 5000 && expq.size() > 0; k++) @(posedge clk);
    if (expq.size() > 0) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, expq[0]);
      expq.delete();
    end
    $display("test %0s over, mismatches %0d", s, n_errors);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ========
  // main sequence
  initial begin
    sys_rst = 1'b1;
    host_board_reset_n = 1'b1;
    format_select_sw = 4'h0;
    flow_mode_sw = 1'b0;
    alarm_state = 1'b0;
    paper_out = 1'b0;
    test_print = 1'b0;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      expq.push_back(d);
      host_link_model_inst.send_par(d, 1'b1);
    end
    done("parallel");
    @(posedge clk) #1 test_print = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, busy}, 8'h01);
    @(posedge clk) #1 test_print = 1'b0;
    host_link_model_inst.send_ser(8'h5a, B1, 0, 3'b100);
    fmt(1);
    host_link_model_inst.send_par(8'ha5, 1'b0);
    done("ignored input");
    // fast parity formats get a wrong-parity frame too; slow ones once, 9600 parity ones never, to save run time
    for (int c = 1; c < 16; c++) begin
      if (c != 9 && c != 14) begin
        fmt(c);
        d = 8'($random(seed));
        ser(d, d, c, 3'b000);
        if (c > 5 && rt[(c - 1) % 5] < 100) ser(d, 8'h3f, c, 3'b001);
      end
    end
    done("formats");
    fmt(1);
    ser(8'h81, 8'h3f, 1, 3'b010);
    repeat (2 * B1) @(posedge clk);
    ser(8'h42, 8'h42, 1, 3'b000);
    done("framing");
    @(posedge clk) #1 host_board_reset_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 host_board_reset_n = 1'b1;
    repeat (10) @(posedge clk);
    ser(8'h24, 8'h3f, 1, 3'b100);
    done("overrun");
    host_link_model_inst.codes.delete();
    @(posedge clk) #1 flow_mode_sw = 1'b1;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int k = 0; k < 2000 && host_link_model_inst.codes.size() < 2; k++) @(posedge clk);
    check(host_link_model_inst.codes[0], 8'h13);
    check(host_link_model_inst.codes[1], 8'h11);
    ser(8'h77, 8'h77, 1, 3'b000);
    @(posedge clk) #1 test_print = 1'b1;
    ser(8'h66, 8'h3f, 1, 3'b100);
    @(posedge clk) #1 test_print = 1'b0;
    done("flow codes");
    @(posedge clk) #1 alarm_state = 1'b1;
    paper_out = 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, alarm_out_n, paper_out_flag}, 8'h01);
    @(posedge clk) #1 alarm_state = 1'b0;
    paper_out = 1'b0;
    done("alarm");
    complete_run();
  end
endmodule

// ### sim/host_link_model.sv
// host model: parallel port and serial line driver, flow code receiver
// assumes clk is the device clock; drives land 1 ns after a rising edge
`timescale 1ns/100ps
module host_link_model #(
  parameter int CODE_BIT = 40
) (
  input wire logic clk,
  input wire logic busy,
  input wire logic dtr,
  input wire logic txd,
  output logic rxd,
  output logic host_strobe_n,
  output logic [7:0] host_byte_bus
);
  logic [7:0] codes[$];
  logic [7:0] c;
  initial begin
    rxd = 1'b1;
    host_strobe_n = 1'b1;
    host_byte_bus = 8'h00;
  end

  // ========
  // parallel byte: data settles before the strobe and outlives it
  task automatic send_par(input logic [7:0] d, input logic obey);
    if (obey) begin
      @(negedge clk);
      while (busy !== 1'b0) @(negedge clk);
    end
    @(posedge clk) #1 host_byte_bus = d;
    repeat (4) @(posedge clk);
    #1 host_strobe_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 host_strobe_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 host_byte_bus = ~d; // released bus shows no stale byte
  endtask

  // ========
  // serial frame; flt: 0 wrong parity, 1 low stop bit, 2 ignore flow state
  task automatic send_ser(input logic [7:0] d, input int bl, input int pm, input logic [2:0] flt);
    logic [9:0] f;
    f = {~flt[1], ^d ^ (pm == 1) ^ flt[0], d};
    if (!flt[2]) begin
      @(negedge clk);
      while (dtr !== 1'b0 || (codes.size() > 0 && codes[$] == 8'h13)) @(negedge clk);
    end
    @(posedge clk) #1 rxd = 1'b0;
    repeat (bl) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      if (i != 8 || pm != 0) begin
        #1 rxd = f[i];
        repeat (bl) @(posedge clk);
      end
    end
    #1 rxd = 1'b1;
  endtask

  // ========
  // flow code receiver, sampled mid bit on the falling edge to avoid races
  initial begin
    forever begin
      @(negedge txd);
      repeat (CODE_BIT / 2) @(negedge clk);
      for (int j = 0; j < 8; j++) begin
        repeat (CODE_BIT) @(negedge clk);
        c[j] = txd;
      end
      codes.push_back(c);
      repeat (CODE_BIT) @(negedge clk);
    end
  end
endmodule

// ### src/flow_code_tx.sv
// serial transmitter for the flow control codes
// assumes the caller holds data and format stable while busy
`timescale 1ns/100ps
module flow_code_tx (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic [host_input_pkg::BIT_CNT_W-1:0] bit_len,
  output logic txd,
  output logic idle
);

  // ==========================================================================
  // frame shifter
  host_input_pkg::tx_state_type state, next_state;
  logic [10:0] frame, next_frame;
  logic [3:0] bits_left, next_bits_left;
  logic [host_input_pkg::BIT_CNT_W-1:0] cnt, next_cnt;
  logic next_txd;

  // frame is start, eight data lsb first, optional parity, one stop
  always_comb begin
    next_state = state;
    next_frame = frame;
    next_bits_left = bits_left;
    next_cnt = cnt;
    next_txd = txd;
    case (state)
      host_input_pkg::TX_IDLE: begin
        next_txd = host_input_pkg::LINE_MARK;
        if (start) begin
          if (parity_en) begin
            next_frame = {host_input_pkg::LINE_MARK, (^data) ^ parity_odd, data, host_input_pkg::LINE_SPACE};
            next_bits_left = 4'hb;
          end else begin
            next_frame = {host_input_pkg::LINE_MARK, host_input_pkg::LINE_MARK, data, host_input_pkg::LINE_SPACE};
            next_bits_left = 4'ha;
          end
          next_cnt = '0;
          next_state = host_input_pkg::TX_SHIFT;
        end
      end
      host_input_pkg::TX_SHIFT: begin
        if (cnt == '0) begin
          if (bits_left == 4'h0) begin
            next_state = host_input_pkg::TX_IDLE;
          end else begin
            next_txd = frame[0];
            next_frame = {host_input_pkg::LINE_MARK, frame[10:1]};
            next_bits_left = bits_left - 4'h1;
            next_cnt = bit_len - 1'b1;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = host_input_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= host_input_pkg::TX_IDLE;
      frame <= '1;
      bits_left <= 4'h0;
      cnt <= '0;
      txd <= host_input_pkg::LINE_MARK;
    end else begin
      state <= next_state;
      frame <= next_frame;
      bits_left <= next_bits_left;
      cnt <= next_cnt;
      txd <= next_txd;
    end
  end

  // idle must not look at start: the caller builds start from idle
  assign idle = (state == host_input_pkg::TX_IDLE);

endmodule

// ### src/host_input_pkg.sv
// constants, carriers and state types for the host input front end
// assumes one 20 MHz clock shared by every user of this package
package host_input_pkg;

  // ==========================================================================
  // clock and line timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BIT_CYCLES_1200 = CLK_HZ / BAUD_1200;
  localparam int unsigned BIT_CYCLES_2400 = CLK_HZ / BAUD_2400;
  localparam int unsigned BIT_CYCLES_4800 = CLK_HZ / BAUD_4800;
  localparam int unsigned BIT_CYCLES_9600 = CLK_HZ / BAUD_9600;
  localparam int unsigned BIT_CYCLES_19200 = CLK_HZ / BAUD_19200;
  localparam int unsigned BIT_CNT_W = 15;
  localparam int unsigned POWERUP_TIME_MS = 500;
  localparam int unsigned POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_TIME_MS;
  localparam int unsigned POWERUP_CNT_W = 24;
  localparam int unsigned ACK_TIME_NS = 2300;
  localparam int unsigned ACK_CYCLES = (ACK_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ==========================================================================
  // buffer and codes
  localparam int unsigned BUF_DEPTH = 2048;
  localparam int unsigned BUF_AW = 11;
  localparam logic [BUF_AW:0] READY_LIMIT = 12'h100;
  localparam logic [7:0] CODE_READY = 8'h11;
  localparam logic [7:0] CODE_NOT_READY = 8'h13;
  localparam logic [7:0] CODE_ERROR = 8'h3f;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  localparam logic [3:0] FMT_PARALLEL = 4'h0;
  localparam logic [3:0] FMT_ODD_FIRST = 4'h6;
  localparam logic [3:0] FMT_EVEN_FIRST = 4'hb;

  // ==========================================================================
  // carriers and states
  typedef struct packed {
    logic serial;
    logic parity_en;
    logic parity_odd;
    logic [2:0] rate;
  } line_cfg_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } buf_write_type;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;
  typedef enum {PAR_IDLE, PAR_HOLD, PAR_ACK} par_state_type;
  typedef enum {TX_IDLE, TX_SHIFT} tx_state_type;

  // four switch code to line format; rate 0..4 is 1200..19200
  function automatic line_cfg_type decode_format(input logic [3:0] code);
    line_cfg_type c;
    c = '0;
    c.serial = (code != FMT_PARALLEL);
    if (code >= FMT_EVEN_FIRST) begin
      c.parity_en = 1'b1;
      c.rate = 3'(code - FMT_EVEN_FIRST);
    end else if (code >= FMT_ODD_FIRST) begin
      c.parity_en = 1'b1;
      c.parity_odd = 1'b1;
      c.rate = 3'(code - FMT_ODD_FIRST);
    end else if (c.serial) begin
      c.rate = 3'(code - 4'h1);
    end
    return c;
  endfunction

endpackage

// ### src/host_input_port.sv
// host data input front end: parallel port, serial receiver, 2K byte buffer
// assumes printer-side status inputs are on clk; pins are synchronised here
//
// Function
// - format switches pick parallel or serial rate/parity
// - frame: start, eight data, parity option, stop
// - flow switch picks code or modem-line flow
// - dtr space when ready, mark when not, in modem-line flow; always space in code flow
// - not ready at 256 free bytes or fewer
// - modem-line flow: character while not ready is an overrun
// - any receive error stores a question mark
// - low stop bit is a framing error
// - parity checked only when parity configured
// - not ready in power-up, test print, reset
// - keep buffering while printing is running
// - fixed 2K byte buffer shared by both inputs
// - byte taken on the active-low strobe
// - busy low only when a byte can be accepted
// - acknowledge pulse ends each busy period started by a strobe
// - alarm drives fault low and halts the block
// - paper out flag follows paper-out state
// - code flow: accept after ready, refuse after not
`timescale 1ns/100ps
module host_input_port #(
  parameter int unsigned BIT_CYCLES_1200 = host_input_pkg::BIT_CYCLES_1200,
  parameter int unsigned BIT_CYCLES_2400 = host_input_pkg::BIT_CYCLES_2400,
  parameter int unsigned BIT_CYCLES_4800 = host_input_pkg::BIT_CYCLES_4800,
  parameter int unsigned POWERUP_CYCLES = host_input_pkg::POWERUP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_board_reset_n,
  input wire logic [3:0] format_select_sw,
  input wire logic flow_mode_sw,
  input wire logic rxd,
  input wire logic [7:0] host_byte_bus,
  input wire logic host_strobe_n,
  input wire logic alarm_state,
  input wire logic paper_out,
  input wire logic test_print,
  input wire logic buf_out_ready,
  output logic busy,
  output logic byte_request_pulse_n,
  output logic alarm_out_n,
  output logic paper_out_flag,
  output logic dtr,
  output logic txd,
  output logic buf_out_valid,
  output logic [7:0] buf_out_data,
  output logic not_ready
);

  // ==========================================================================
  // pin synchronisers
  logic hrst_meta, hrst_sync;
  logic [3:0] fmt_meta, fmt_sync;
  logic flow_meta, flow_sync;
  logic rxd_meta, rxd_sync;
  logic stb_meta, stb_sync, stb_prev;
  logic [7:0] bus_meta, bus_sync;

  // two flops per pin; idle line and strobe come up high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrst_meta <= 1'b0;
      hrst_sync <= 1'b0;
      fmt_meta <= 4'h0;
      fmt_sync <= 4'h0;
      flow_meta <= 1'b0;
      flow_sync <= 1'b0;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      stb_meta <= 1'b1;
      stb_sync <= 1'b1;
      stb_prev <= 1'b1;
      bus_meta <= 8'h00;
      bus_sync <= 8'h00;
    end else begin
      hrst_meta <= host_board_reset_n;
      hrst_sync <= hrst_meta;
      fmt_meta <= format_select_sw;
      fmt_sync <= fmt_meta;
      flow_meta <= flow_mode_sw;
      flow_sync <= flow_meta;
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
      stb_meta <= host_strobe_n;
      stb_sync <= stb_meta;
      stb_prev <= stb_sync;
      bus_meta <= host_byte_bus;
      bus_sync <= bus_meta;
    end
  end

  // ==========================================================================
  // configuration and readiness
  logic blk_rst;
  host_input_pkg::line_cfg_type cfg;
  logic [host_input_pkg::BIT_CNT_W-1:0] bit_len;
  logic [host_input_pkg::POWERUP_CNT_W-1:0] pwr_cnt, next_pwr_cnt;
  logic powering;
  logic [host_input_pkg::BUF_AW:0] count, next_count, free_space;
  logic hold;

  assign blk_rst = sys_rst || !hrst_sync;
  assign cfg = host_input_pkg::decode_format(fmt_sync);

  // rate index to bit period; 19200 also covers unused codes
  always_comb begin
    case (cfg.rate)
      3'h0: bit_len = host_input_pkg::BIT_CNT_W'(BIT_CYCLES_1200);
      3'h1: bit_len = host_input_pkg::BIT_CNT_W'(BIT_CYCLES_2400);
      3'h2: bit_len = host_input_pkg::BIT_CNT_W'(BIT_CYCLES_4800);
      3'h3: bit_len = host_input_pkg::BIT_CNT_W'(host_input_pkg::BIT_CYCLES_9600);
      default: bit_len = host_input_pkg::BIT_CNT_W'(host_input_pkg::BIT_CYCLES_19200);
    endcase
  end

  // power-up wait restarts on every reset so a reset also reads busy
  always_comb begin
    next_pwr_cnt = pwr_cnt;
    if (powering) begin
      next_pwr_cnt = pwr_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      pwr_cnt <= '0;
    end else begin
      pwr_cnt <= next_pwr_cnt;
    end
  end

  assign powering = (pwr_cnt != host_input_pkg::POWERUP_CNT_W'(POWERUP_CYCLES));
  assign free_space = (host_input_pkg::BUF_AW + 1)'(host_input_pkg::BUF_DEPTH) - count;
  assign hold = blk_rst || powering || test_print || alarm_state
    || (free_space <= host_input_pkg::READY_LIMIT);
  assign not_ready = hold;

  // ==========================================================================
  // flow control
  logic xoff_sent, next_xoff_sent;
  logic tx_start, tx_idle, refuse;

  // in serial code flow, a code goes out once the transmitter is idle and the sent state disagrees with readiness
  assign tx_start = cfg.serial && flow_sync && tx_idle && (hold != xoff_sent);

  always_comb begin
    next_xoff_sent = xoff_sent;
    if (tx_start) begin
      next_xoff_sent = hold;
    end
  end

  // starts clear so the first code after reset is the not-ready one
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      xoff_sent <= 1'b0;
    end else begin
      xoff_sent <= next_xoff_sent;
    end
  end

  assign refuse = flow_sync ? xoff_sent : hold;
  assign dtr = (!flow_sync && hold) ? host_input_pkg::LINE_MARK : host_input_pkg::LINE_SPACE;

  flow_code_tx u_flow_tx (
    .clk(clk),
    .rst(blk_rst),
    .start(tx_start),
    .data(hold ? host_input_pkg::CODE_NOT_READY : host_input_pkg::CODE_READY),
    .parity_en(cfg.parity_en),
    .parity_odd(cfg.parity_odd),
    .bit_len(bit_len),
    .txd(txd),
    .idle(tx_idle)
  );

  // ==========================================================================
  // serial receiver
  host_input_pkg::rx_state_type rx_state, next_rx_state;
  logic [host_input_pkg::BIT_CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_shift, next_rx_shift;
  logic rx_par, next_rx_par;
  logic rx_overrun, next_rx_overrun;
  host_input_pkg::buf_write_type rx_wr;
  logic parity_bad, frame_bad;

  assign parity_bad = cfg.parity_en && ((^{rx_shift, rx_par}) != cfg.parity_odd);
  assign frame_bad = (rxd_sync == host_input_pkg::LINE_SPACE);

  // samples mid-bit: half a bit after the start edge, then whole bits
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_par = rx_par;
    next_rx_overrun = rx_overrun;
    rx_wr = '0;
    if (rx_state != host_input_pkg::RX_IDLE && rx_cnt != '0) begin
      next_rx_cnt = rx_cnt - 1'b1;
    end else begin
      case (rx_state)
        host_input_pkg::RX_IDLE: begin
          if (cfg.serial && rxd_sync == host_input_pkg::LINE_SPACE) begin
            next_rx_state = host_input_pkg::RX_START;
            next_rx_cnt = bit_len >> 1;
            next_rx_overrun = refuse || (count == (host_input_pkg::BUF_AW + 1)'(host_input_pkg::BUF_DEPTH));
          end
        end
        host_input_pkg::RX_START: begin
          // a start bit gone by mid-bit was only a glitch
          next_rx_state = rxd_sync ? host_input_pkg::RX_IDLE : host_input_pkg::RX_DATA;
          next_rx_cnt = bit_len - 1'b1;
          next_rx_bit = 3'h0;
        end
        host_input_pkg::RX_DATA: begin
          next_rx_shift = {rxd_sync, rx_shift[7:1]};
          next_rx_bit = rx_bit + 3'h1;
          next_rx_cnt = bit_len - 1'b1;
          if (rx_bit == 3'h7) begin
            next_rx_state = cfg.parity_en ? host_input_pkg::RX_PARITY : host_input_pkg::RX_STOP;
          end
        end
        host_input_pkg::RX_PARITY: begin
          next_rx_par = rxd_sync;
          next_rx_cnt = bit_len - 1'b1;
          next_rx_state = host_input_pkg::RX_STOP;
        end
        host_input_pkg::RX_STOP: begin
          rx_wr.valid = 1'b1;
          rx_wr.data = (frame_bad || parity_bad || rx_overrun) ? host_input_pkg::CODE_ERROR : rx_shift;
          next_rx_state = host_input_pkg::RX_IDLE;
        end
        default: next_rx_state = host_input_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      rx_state <= host_input_pkg::RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_par <= next_rx_par;
      rx_overrun <= next_rx_overrun;
    end
  end

  // ==========================================================================
  // parallel port
  host_input_pkg::par_state_type par_state, next_par_state;
  logic [5:0] ack_cnt, next_ack_cnt;
  host_input_pkg::buf_write_type par_wr;

  // busy rises on the strobe, acknowledge runs, busy falls as it ends
  always_comb begin
    next_par_state = par_state;
    next_ack_cnt = ack_cnt;
    par_wr = '0;
    case (par_state)
      host_input_pkg::PAR_IDLE: begin
        if (!cfg.serial && !busy && stb_prev && !stb_sync) begin
          par_wr.valid = 1'b1;
          par_wr.data = bus_sync;
          next_par_state = host_input_pkg::PAR_HOLD;
        end
      end
      host_input_pkg::PAR_HOLD: begin
        if (!hold && stb_sync) begin
          next_ack_cnt = 6'(host_input_pkg::ACK_CYCLES - 1);
          next_par_state = host_input_pkg::PAR_ACK;
        end
      end
      host_input_pkg::PAR_ACK: begin
        next_ack_cnt = ack_cnt - 6'h01;
        if (ack_cnt == 6'h00) begin
          next_par_state = host_input_pkg::PAR_IDLE;
        end
      end
      default: next_par_state = host_input_pkg::PAR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      par_state <= host_input_pkg::PAR_IDLE;
      ack_cnt <= 6'h00;
    end else begin
      par_state <= next_par_state;
      ack_cnt <= next_ack_cnt;
    end
  end

  assign busy = cfg.serial || hold || (par_state != host_input_pkg::PAR_IDLE);
  assign byte_request_pulse_n = (par_state != host_input_pkg::PAR_ACK);

  // ==========================================================================
  // input buffer
  logic [7:0] mem [host_input_pkg::BUF_DEPTH];
  logic [host_input_pkg::BUF_AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  host_input_pkg::buf_write_type wr;
  logic wr_ok, rd_ok;
  logic next_out_valid;
  logic [7:0] next_out_data;

  // only the selected port can write, so the mux never collides
  assign wr = cfg.serial ? rx_wr : par_wr;
  assign wr_ok = wr.valid && (count != (host_input_pkg::BUF_AW + 1)'(host_input_pkg::BUF_DEPTH));
  // draining stops in alarm; filling goes on while printing
  assign rd_ok = (count != '0) && (!buf_out_valid || buf_out_ready) && !alarm_state;

  always_comb begin
    next_wr_ptr = wr_ptr + host_input_pkg::BUF_AW'(wr_ok);
    next_rd_ptr = rd_ptr + host_input_pkg::BUF_AW'(rd_ok);
    next_count = count + (host_input_pkg::BUF_AW + 1)'(wr_ok) - (host_input_pkg::BUF_AW + 1)'(rd_ok);
    next_out_valid = buf_out_valid;
    next_out_data = buf_out_data;
    if (rd_ok) begin
      next_out_valid = 1'b1;
      next_out_data = mem[rd_ptr];
    end else if (buf_out_ready && !alarm_state) begin
      next_out_valid = 1'b0;
    end
  end

  // storage array holds no reset; pointers, count and the output register do
  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      buf_out_valid <= 1'b0;
      buf_out_data <= 8'h00;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      buf_out_valid <= next_out_valid;
      buf_out_data <= next_out_data;
    end
  end

  // ==========================================================================
  // status pins
  assign alarm_out_n = !alarm_state;
  assign paper_out_flag = paper_out;

endmodule
